// file: rtl/watch_timer.sv
// Watch timer with concurrent watch and interval functions, Wishbone slave
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
`include "watch_timer_consts.svh"

module watch_timer #(
   parameter int ADDR_W      = `WT_ADDR_W,
   parameter int PRESCALER_W = `WT_PRESCALER_W,
   parameter int COUNTER_W   = `WT_COUNTER_W,
   parameter int PRS_DIV     = `WT_PRS_DIV_LOG2
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              sub_clk_i,
   output logic                   watch_interrupt_o,
   output logic                   interval_interrupt_o
);

   localparam logic [ADDR_W-1:0] MODE_ADDR =
      ADDR_W'({`WT_MODE_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] SET_ADDR =
      ADDR_W'({`WT_SET_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] CLR_ADDR =
      ADDR_W'({`WT_CLR_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] STATUS_ADDR =
      ADDR_W'({`WT_STATUS_IDX, 2'b00});

   generate
      if (ADDR_W < `WT_ADDR_W) begin : g_bad_addr
         $error("watch_timer: ADDR_W too narrow for the register map");
      end
      if (PRESCALER_W != `WT_PRESCALER_W) begin : g_bad_pre
         $error("watch_timer: interval decode needs an 11-bit prescaler");
      end
      if (COUNTER_W != `WT_COUNTER_W) begin : g_bad_cnt
         $error("watch_timer: watch decode needs a 5-bit counter");
      end
      if (PRS_DIV < 1 || PRS_DIV > 16) begin : g_bad_div
         $error("watch_timer: PRS_DIV must lie between 1 and 16");
      end
   endgenerate

   watch_timer_pkg::watch_mode_control_s watch_mode_control_reg;
   watch_timer_pkg::watch_mode_control_s mode_next;
   watch_timer_pkg::bus_state_e          bus_state_reg;
   watch_timer_pkg::bus_state_e          bus_state_next;

   logic [PRESCALER_W-1:0] prescaler_reg;
   logic [COUNTER_W-1:0]   counter_reg;
   logic                   rate_tick;
   logic                   fwx_tick;
   logic                   fwx_tap;
   logic                   interval_event;
   logic                   watch_event;
   logic                   hit_mode;
   logic                   hit_set;
   logic                   hit_clr;
   logic                   hit_status;
   logic [31:0]            status_word;
   logic                   interval_hit;
   logic                   watch_hit;
   logic                   bus_req;
   logic                   write_now;
   logic                   timer_on;
   logic                   watch_on;
   logic [31:0]            read_value;
   logic [7:0]             mode_bits;
   logic [7:0]             wr_byte;

   assign mode_bits = watch_mode_control_reg;
   assign wr_byte   = wb_dat_i[7:0];
   assign timer_on  = watch_mode_control_reg.timer_enable_bit;
   assign watch_on  = watch_mode_control_reg.timer_enable_bit &
                      watch_mode_control_reg.counter_run_bit;

   // Watch clock source
   watch_tick_gen #(
      .DIV_LOG2 (PRS_DIV)
   ) u_tick (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .sub_clk_i    (sub_clk_i),
      .select_sub_i (watch_mode_control_reg.count_clock_select),
      .enable_i     (timer_on),
      .tick_o       (rate_tick)
   );

   // Wishbone classic slave: ack one cycle after the request
   assign bus_req = wb_cyc_i & wb_stb_i;

   always_comb begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         watch_timer_pkg::BUS_IDLE: begin
            if (bus_req) begin
               bus_state_next = watch_timer_pkg::BUS_ACK;
            end
         end
         watch_timer_pkg::BUS_ACK: begin
            bus_state_next = watch_timer_pkg::BUS_IDLE;
         end
         default: begin
            bus_state_next = watch_timer_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_reg <= watch_timer_pkg::BUS_IDLE;
      end else begin
         bus_state_reg <= bus_state_next;
      end
   end

   assign wb_ack_o  = (bus_state_reg == watch_timer_pkg::BUS_ACK) & bus_req;
   assign write_now = wb_ack_o & wb_we_i & wb_sel_i[0];

   // Address decode shared by the write and read paths
   assign hit_mode   = (wb_adr_i == MODE_ADDR);
   assign hit_set    = (wb_adr_i == SET_ADDR);
   assign hit_clr    = (wb_adr_i == CLR_ADDR);
   assign hit_status = (wb_adr_i == STATUS_ADDR);

   // Bit set and clear ports let software touch one bit without a
   // read-modify-write race against itself
   always_comb begin
      mode_next = watch_mode_control_reg;
      if (write_now) begin
         if (hit_mode) begin
            mode_next = wr_byte;
         end else if (hit_set) begin
            mode_next = mode_bits | wr_byte;
         end else if (hit_clr) begin
            mode_next = mode_bits & ~wr_byte;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         watch_mode_control_reg <= `WT_MODE_RESET;
      end else begin
         watch_mode_control_reg <= mode_next;
      end
   end

   // Status word is a view of the live counters, for test only
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`WT_STAT_PRE_LO +: PRESCALER_W] = prescaler_reg;
      status_word[`WT_STAT_CNT_LO +: COUNTER_W]   = counter_reg;
   end

   // Read data prepared while ack is pending; reads change no state
   always_comb begin
      read_value = 32'h0000_0000;
      if (hit_mode) begin
         read_value[7:0] = mode_bits;
      end else if (hit_status) begin
         read_value = status_word;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req && bus_state_reg == watch_timer_pkg::BUS_IDLE) begin
         wb_dat_o <= wb_we_i ? 32'h0000_0000 : read_value;
      end
   end

   // Shared prescaler; only reset and the enable bit clear it
   always_ff @(posedge clk_i) begin
      if (rst_i || !timer_on) begin
         prescaler_reg <= '0;
      end else if (rate_tick) begin
         prescaler_reg <= prescaler_reg + 1'b1;
      end
   end

   // Interval elapses when the low 4+code prescaler bits wrap
   always_comb begin
      interval_hit = 1'b0;
      case (watch_mode_control_reg.prescale_interval_sel)
         3'h0: interval_hit = &prescaler_reg[3:0];
         3'h1: interval_hit = &prescaler_reg[4:0];
         3'h2: interval_hit = &prescaler_reg[5:0];
         3'h3: interval_hit = &prescaler_reg[6:0];
         3'h4: interval_hit = &prescaler_reg[7:0];
         3'h5: interval_hit = &prescaler_reg[8:0];
         3'h6: interval_hit = &prescaler_reg[9:0];
         3'h7: interval_hit = &prescaler_reg[10:0];
         default: interval_hit = 1'b0;
      endcase
   end

   // Long watch intervals step once per 2^9 watch clocks. The prescaler
   // is not realigned on a restart, hence the first-period error of up
   // to 2^9 watch clocks.
   assign fwx_tap = &prescaler_reg[`WT_FWX_DIV_LOG2-1:0];

   always_comb begin
      fwx_tick  = 1'b0;
      watch_hit = 1'b0;
      case (watch_mode_control_reg.watch_interval_sel)
         2'b00: begin
            fwx_tick  = rate_tick & fwx_tap;
            watch_hit = &counter_reg[`WT_WATCH_LONG_BITS-1:0];
         end
         2'b01: begin
            fwx_tick  = rate_tick & fwx_tap;
            watch_hit = &counter_reg[`WT_WATCH_SHORT_BITS-1:0];
         end
         2'b10: begin
            fwx_tick  = rate_tick;
            watch_hit = &counter_reg[`WT_WATCH_LONG_BITS-1:0];
         end
         2'b11: begin
            fwx_tick  = rate_tick;
            watch_hit = &counter_reg[`WT_WATCH_SHORT_BITS-1:0];
         end
         default: begin
            fwx_tick  = 1'b0;
            watch_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !watch_on) begin
         counter_reg <= '0;
      end else if (fwx_tick) begin
         counter_reg <= counter_reg + 1'b1;
      end
   end

   // Events are formed from the tick before the counters move
   assign interval_event = timer_on & rate_tick & interval_hit;
   assign watch_event    = watch_on & fwx_tick & watch_hit;

   // Interrupt pulses, one clock wide each
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         interval_interrupt_o <= 1'b0;
      end else begin
         interval_interrupt_o <= interval_event;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         watch_interrupt_o <= 1'b0;
      end else begin
         watch_interrupt_o <= watch_event;
      end
   end

endmodule : watch_timer

// file: include/watch_timer_consts.svh
// Offsets, field positions, reset values and timing counts of the watch timer
// Function
// - Watch and interval functions run together off one shared prescaler, each with its own interrupt.
// - While the watch function runs, a watch interrupt is raised once per selected watch interval.
// - While the interval function runs, an interval interrupt is raised once per selected prescaler interval.
// - Clock select 0 counts the peripheral clock divided by 128, 1 counts the subsystem clock.
// - Interval codes 0 to 7 give periods of 2^4 to 2^11 watch clocks, doubling each step.
// - Watch codes 00, 01, 10, 11 give 2^14, 2^13, 2^5 and 2^4 watch clocks between interrupts.
// - Counter-run bit 1 runs the 5-bit counter; 0 stops and clears it.
// - Enable bit 0 stops everything and clears prescaler and counter; 1 enables operation.
// - Any reset clears the whole mode register to zero.
// - The mode register takes whole-byte writes and single-bit set or clear writes.
// - The watch function starts only when enable and counter-run are both 1.
// - The interval function counts whenever enable is 1, whatever counter-run holds.
// - Clearing only counter-run leaves the prescaler running and uncleared.
// - After such a restart the first watch interrupt may be off by up to 2^9 watch clocks, later ones exact.
`ifndef WATCH_TIMER_CONSTS_SVH
`define WATCH_TIMER_CONSTS_SVH

// Register indices; byte address is four times the index
`define WT_MODE_IDX        16'hFF8F
`define WT_SET_IDX         16'hFF90
`define WT_CLR_IDX         16'hFF91
`define WT_STATUS_IDX      16'hFF92
`define WT_ADDR_W          18

`define WT_MODE_RESET      8'h00

// Mode register field positions
`define WT_ENABLE_BIT      0
`define WT_RUN_BIT         1
`define WT_WSEL_LO         2
`define WT_WSEL_HI         3
`define WT_PSEL_LO         4
`define WT_PSEL_HI         6
`define WT_CLKSEL_BIT      7

// Status register field positions
`define WT_STAT_PRE_LO     0
`define WT_STAT_CNT_LO     16

// Timing counts
`define WT_PRS_DIV_LOG2    7
`define WT_PRESCALER_W     11
`define WT_COUNTER_W       5
`define WT_PSEL_BASE_LOG2  4
`define WT_FWX_DIV_LOG2    9
`define WT_WATCH_LONG_BITS 5
`define WT_WATCH_SHORT_BITS 4

`endif

// file: include/watch_timer_pkg.sv
// Types shared by the watch timer design files
package watch_timer_pkg;

   typedef struct packed {
      logic       count_clock_select;
      logic [2:0] prescale_interval_sel;
      logic [1:0] watch_interval_sel;
      logic       counter_run_bit;
      logic       timer_enable_bit;
   } watch_mode_control_s;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_e;

endpackage : watch_timer_pkg

// file: rtl/watch_tick_gen.sv
// Watch clock tick source: divided peripheral clock or synchronised subsystem
`timescale 1ns/10ps
`include "watch_timer_consts.svh"

module watch_tick_gen #(
   parameter int DIV_LOG2 = `WT_PRS_DIV_LOG2
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic sub_clk_i,
   input  wire logic select_sub_i,
   input  wire logic enable_i,
   output logic      tick_o
);

   logic [DIV_LOG2-1:0] div_reg;
   logic                sub_meta_reg;
   logic                sub_sync_reg;
   logic                sub_last_reg;
   logic                sub_rise;
   logic                div_wrap;

   generate
      if (DIV_LOG2 < 1) begin : g_bad_div
         $error("watch_tick_gen: DIV_LOG2 must be at least 1");
      end
   endgenerate

   // Divider restarts from zero on enable so start-up phase is fixed
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sub_meta_reg <= 1'b0;
         sub_sync_reg <= 1'b0;
         sub_last_reg <= 1'b0;
      end else begin
         sub_meta_reg <= sub_clk_i;
         sub_sync_reg <= sub_meta_reg;
         sub_last_reg <= sub_sync_reg;
      end
   end

   assign sub_rise = sub_sync_reg & ~sub_last_reg;
   assign div_wrap = &div_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= select_sub_i ? sub_rise : div_wrap;
      end
   end

endmodule : watch_tick_gen

// file: sim/watch_timer_monitor.sv
// Checker of bus answers, interrupt pulses and interrupt periods
`timescale 1ns/10ps
module watch_timer_monitor #(
   parameter int ADDR_W  = 18,
   parameter int PRS_DIV = 7
) (
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0]        wb_sel_i,
   input wire logic [31:0]       wb_dat_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   input wire logic              sub_clk_i,
   input wire logic              watch_interrupt_o,
   input wire logic              interval_interrupt_o
);
   logic [7:0]  mode_q;
   logic [31:0] ic_q, wc_q;
   logic        iv_q, wv_q, wr;
   logic [4:0]  wlog;
   assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
   assign wlog = mode_q[3] ? (mode_q[2] ? 5'd4 : 5'd5)
                           : (mode_q[2] ? 5'd13 : 5'd14);
   // Shadow of the mode register, built from acked writes
   always_ff @(posedge clk_i) begin
      if (rst_i)
         mode_q <= 8'h00;
      else if (wr && wb_adr_i == ADDR_W'(18'h3FE3C))
         mode_q <= wb_dat_i[7:0];
      else if (wr && wb_adr_i == ADDR_W'(18'h3FE40))
         mode_q <= mode_q | wb_dat_i[7:0];
      else if (wr && wb_adr_i == ADDR_W'(18'h3FE44))
         mode_q <= mode_q & ~wb_dat_i[7:0];
   end
   // Gaps count only between two pulses with no write in between
   always_ff @(posedge clk_i) begin
      if (rst_i || wr) begin
         ic_q <= 32'h0;
         iv_q <= 1'b0;
      end else if (interval_interrupt_o) begin
         ic_q <= 32'h1;
         iv_q <= 1'b1;
      end else
         ic_q <= ic_q + 32'h1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || wr) begin
         wc_q <= 32'h0;
         wv_q <= 1'b0;
      end else if (watch_interrupt_o) begin
         wc_q <= 32'h1;
         wv_q <= 1'b1;
      end else
         wc_q <= wc_q + 32'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_timing: assert property (
      $rose(wb_stb_i) && wb_cyc_i |-> !wb_ack_o ##1 wb_ack_o)
      else $error("ack not one cycle after request");
   a_watch_pulse: assert property (
      watch_interrupt_o |=> !watch_interrupt_o)
      else $error("watch interrupt longer than one cycle");
   a_intv_pulse: assert property (
      $rose(interval_interrupt_o) |=> $fell(interval_interrupt_o))
      else $error("interval interrupt longer than one cycle");
   a_reset_quiet: assert property (
      $fell(rst_i) |-> !watch_interrupt_o && !interval_interrupt_o)
      else $error("interrupt right after reset");
   a_intv_stopped: assert property (
      !mode_q[0] && !$past(mode_q[0]) |-> !interval_interrupt_o)
      else $error("interval interrupt while disabled");
   a_watch_stopped: assert property (
      !(mode_q[0] && mode_q[1]) && !$past(mode_q[0] && mode_q[1])
      |-> !watch_interrupt_o)
      else $error("watch interrupt while not started");
   a_mode_readback: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == ADDR_W'(18'h3FE3C)
      |-> wb_dat_o == {24'h0, mode_q})
      else $error("mode read differs from last write");
   a_intv_period: assert property (
      interval_interrupt_o && iv_q && !mode_q[7]
      |-> ic_q == (32'd1 << (4 + mode_q[6:4] + PRS_DIV)))
      else $error("interval period wrong");
   a_watch_period: assert property (
      watch_interrupt_o && wv_q && !mode_q[7]
      |-> wc_q == (32'd1 << (wlog + PRS_DIV)))
      else $error("watch period wrong");
   c_watch: cover property (watch_interrupt_o && wv_q);
   c_intv: cover property (interval_interrupt_o && iv_q);
   c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : watch_timer_monitor

bind watch_timer watch_timer_monitor #(.ADDR_W(ADDR_W), .PRS_DIV(PRS_DIV))
   i_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .sub_clk_i(sub_clk_i),
   .watch_interrupt_o(watch_interrupt_o),
   .interval_interrupt_o(interval_interrupt_o));

// file: sim/tb_watch_timer.sv
// Self-checking bench of the watch timer registers and interrupt timing
`timescale 1ns/10ps
module tb_watch_timer;
   // Short divider keeps the longest watch period within the run
   localparam int PD = 1;
   localparam logic [17:0] A_MODE = 18'h3FE3C;
   localparam logic [17:0] A_SET  = 18'h3FE40;
   localparam logic [17:0] A_CLR  = 18'h3FE44;
   localparam logic [17:0] A_STAT = 18'h3FE48;
   logic        clk_i, rst_i, cyc, stb, we, ack, wirq, iirq;
   logic        sub_clk, sub_on;
   logic [2:0]  sc;
   logic [17:0] adr;
   logic [3:0]  sel;
   logic [31:0] dat, rdat, q;
   int          err_count, n_tests;
   time         t0, t1;

   watch_timer #(.PRS_DIV(PD)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sub_clk_i(sub_clk), .watch_interrupt_o(wirq),
      .interval_interrupt_o(iirq));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Subsystem clock of eight cycles, still while switched off
   always @(posedge clk_i) begin
      if (sub_on) begin
         sc <= sc + 3'h1;
         sub_clk <= sc[2];
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic bus(input logic w, input logic [17:0] a,
                      input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50)
         err_count++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask : wr

   task automatic rd(input logic [17:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00, 4'h1);
      check(q, e);
   endtask : rd

   task automatic pulse(input bit w, output time t);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while ((w ? wirq : iirq) !== 1'b1 && n < 40000);
      if (n >= 40000)
         err_count++;
      t = $time;
   endtask : pulse

   task automatic t_regs;
      rd(A_MODE, 32'h0);
      rd(18'h00010, 32'h0);
      wr(A_MODE, 8'hA4);
      rd(A_MODE, 32'hA4);
      wr(A_SET, 8'h01);
      rd(A_MODE, 32'hA5);
      wr(A_CLR, 8'h84);
      rd(A_MODE, 32'h21);
      bus(1'b1, A_MODE, 8'hFF, 4'h0);
      rd(A_MODE, 32'h21);
      wr(A_MODE, 8'h00);
      rd(A_STAT, 32'h0);
   endtask : t_regs

   task automatic t_interval;
      for (int c = 0; c < 8; c++) begin
         wr(A_MODE, 8'h00);
         wr(A_MODE, {1'b0, c[2:0], 4'b0001});
         pulse(1'b0, t0);
         pulse(1'b0, t1);
         check(32'((t1 - t0) / 5), 32'd1 << (4 + c + PD));
      end
   endtask : t_interval

   task automatic t_watch;
      int e;
      for (int s = 3; s >= 0; s--) begin
         e = 1 << ((s == 3 ? 4 : s == 2 ? 5 : s == 1 ? 13 : 14) + PD);
         wr(A_MODE, 8'h00);
         wr(A_MODE, {4'h0, s[1:0], 2'b11});
         t0 = $time;
         pulse(1'b1, t1);
         // Start point is a bus edge, so allow a few cycles of slack
         check(32'(((t1 - t0) / 5 + 8) >> 4), 32'(e >> 4));
         if (s > 1) begin
            pulse(1'b1, t0);
            check(32'((t0 - t1) / 5), 32'(e));
         end
      end
   endtask : t_watch

   task automatic t_restart;
      wr(A_MODE, 8'h03);
      pulse(1'b0, t0);
      wr(A_CLR, 8'h02);
      bus(1'b0, A_STAT, 8'h00, 4'h1);
      check(32'(q[20:16]), 32'h0);
      wr(A_SET, 8'h02);
      pulse(1'b0, t1);
      check(32'((t1 - t0) / 5), 32'd1 << (4 + PD));
   endtask : t_restart

   task automatic t_subclk;
      wr(A_MODE, 8'h00);
      sub_on <= 1'b1;
      wr(A_MODE, 8'h81);
      pulse(1'b0, t0);
      pulse(1'b0, t1);
      check(32'((t1 - t0) / 5), 32'd128);
      sub_on <= 1'b0;
   endtask : t_subclk

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up

   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, sub_clk, sub_on} = 5'h00;
      {adr, sel, dat, sc} = '0;
      err_count = 0;
      n_tests = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs;
      t_interval;
      t_watch;
      t_restart;
      t_subclk;
      wrap_up;
   end
   // About 70k cycles of tests, so this only fires on a hang
   initial begin
      repeat (100000) @(posedge clk_i);
      err_count++;
      wrap_up;
   end
endmodule : tb_watch_timer
